/* File: logic/ceu_pkg.sv */
package ceu_pkg;

  // ----------------------------------------------------------------
  // special register numbers
  // ----------------------------------------------------------------
  localparam logic [9:0]  SPR_SYNDROME     = 10'h3D4; // 980
  localparam logic [9:0]  SPR_DATA_FAULT   = 10'h3D5; // 981
  localparam logic [9:0]  SPR_CRIT_ADDR    = 10'h3DE; // 990
  localparam logic [9:0]  SPR_CRIT_STATE   = 10'h3DF; // 991
  localparam logic [9:0]  SPR_VEC_PREFIX   = 10'h3D6; // 982

  // ----------------------------------------------------------------
  // vector offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_CRIT_INPUT   = 16'h0100;
  localparam logic [15:0] VEC_MACH_CHECK   = 16'h0200;

  // ----------------------------------------------------------------
  // machine state bit positions, counted from lsb (bit 31 big-endian = 0)
  // ----------------------------------------------------------------
  localparam int MS_AP  = 25;
  localparam int MS_APE = 19;
  localparam int MS_WE  = 18;
  localparam int MS_CE  = 17;
  localparam int MS_EE  = 15;
  localparam int MS_PR  = 14;
  localparam int MS_FP  = 13;
  localparam int MS_ME  = 12;
  localparam int MS_FE0 = 11;
  localparam int MS_DWE = 10;
  localparam int MS_DE  = 9;
  localparam int MS_FE1 = 8;
  localparam int MS_IR  = 5;
  localparam int MS_DR  = 4;

  // fields cleared on critical input (machine check enable kept)
  localparam logic [31:0] CRIT_CLEAR_MASK  = 32'h020E_EF30;
  // machine check additionally clears machine check enable
  localparam logic [31:0] MCHK_CLEAR_MASK  = 32'h020E_FF30;

  // syndrome bit for fetch error (big-endian bit 0)
  localparam int SYN_FETCH_ERR = 31;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RESET_WORD       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // exception kinds reported to the unit
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    CEU_CAUSE_NONE      = 3'h0,
    CEU_CAUSE_SYNDROME  = 3'h1, // other exception writing syndrome
    CEU_CAUSE_DATA_ADDR = 3'h2  // alignment / data storage / data miss
  } ceu_cause_t;

endpackage

/* File: logic/ceu_link_if.sv */
`timescale 1ns/1ns
// wires between the exception unit and the interrupt controller / bus error sources
interface ceu_link_if;
  logic crit_req;        // critical-interrupt input, level
  logic fetch_bus_err;   // instruction-side bus error, level
  logic data_bus_err;    // data-side bus error, level
  logic crit_taken;      // unit took a critical-input interrupt, pulse
  logic mchk_taken;      // unit took a machine check, pulse

  modport core
  (
    input  crit_req,
    input  fetch_bus_err,
    input  data_bus_err,
    output crit_taken,
    output mchk_taken
  );

  modport ext
  (
    output crit_req,
    output fetch_bus_err,
    output data_bus_err,
    input  crit_taken,
    input  mchk_taken
  );
endinterface

/* File: logic/ceu_syndrome.sv */
`timescale 1ns/1ns
// syndrome register update: cause bits and fetch-error flag, sticky while machine checks are disabled
module ceu_syndrome
  import ceu_pkg::*;
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        machine_check_enable_i,
  input  wire logic        fetch_mchk_i,     // fetch error executed this cycle
  input  wire logic        other_exc_i,      // another exception updates syndrome
  input  wire logic [31:0] other_bits_i,     // cause bits of that exception
  input  wire logic        sw_write_i,
  input  wire logic [31:0] sw_data_i,
  output logic      [31:0] syndrome_register_o
);

  typedef struct packed
  {
    logic [31:0] syn;
  } ceu_syn_state_t;

  ceu_syn_state_t r;
  ceu_syn_state_t next_r;

  // --------------------------------------------------------------
  // next value
  // --------------------------------------------------------------
  always_comb
  begin
    logic [31:0] v;
    v      = r.syn;
    next_r = r;
    if (sw_write_i)
    begin
      v = sw_data_i;                                      // software may clear the flag
    end
    if (other_exc_i)
    begin
      v = other_bits_i & ~(32'h1 << SYN_FETCH_ERR);       // see RULE_01
      // flag survives so a masked fetch error is never lost; see RULE_02
      if (!machine_check_enable_i)
      begin
        v[SYN_FETCH_ERR] = r.syn[SYN_FETCH_ERR] | fetch_mchk_i;
      end
    end
    if (fetch_mchk_i)
    begin
      if (machine_check_enable_i)
      begin
        v = 32'h1 << SYN_FETCH_ERR;                       // see RULE_03
      end
      else
      begin
        v[SYN_FETCH_ERR] = 1'b1;                          // see RULE_20
      end
    end
    next_r.syn = v;
  end

  // --------------------------------------------------------------
  // register
  // --------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      r.syn <= RESET_WORD;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign syndrome_register_o = r.syn;

endmodule

/* File: logic/ceu_core.sv */
`timescale 1ns/1ns
// Overview of operation
// RULE_01: exception sets its cause, clears others
// RULE_02: fetch flag kept while machine checks disabled
// RULE_03: enabled fetch check sets flag only
// RULE_04: syndrome at special register 980
// RULE_05: fault address captures data operand address
// RULE_06: fault address at special register 981
// RULE_07: critical input vector 0x0100, critical return
// RULE_08: controller holds critical request asserted
// RULE_09: controller holds request until software clears
// RULE_10: critical enable gates critical input
// RULE_11: critical input keeps machine check enable
// RULE_12: critical save address gets next instruction
// RULE_13: critical save state gets state, fields cleared
// RULE_14: machine check vector 0x0200, critical return
// RULE_15: separate fetch and data error inputs
// RULE_16: machine check enable gates error interrupts
// RULE_17: machine check disables all maskable interrupts
// RULE_18: fetch error raised only on execution
// RULE_19: fetch check invalidates its cache line
// RULE_20: every fetch check sets the flag
// RULE_21: handler clears flag before returning
// RULE_22: critical return restores state from save
// RULE_23: target is prefix high half plus offset
// RULE_24: inputs sampled as level requests
module ceu_core
  import ceu_pkg::*;
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_I,
  ceu_link_if.core         LINK,
  // software special-register port
  input  wire logic [9:0]  SPR_ADDR_I,
  input  wire logic [31:0] SPR_WDATA_I,
  input  wire logic        SPR_WR_I,
  input  wire logic        SPR_RD_I,
  output logic      [31:0] SPR_RDATA_O,
  // pipeline side
  input  wire logic [31:0] NEXT_PC_I,        // next sequential instruction
  input  wire logic [31:0] EXEC_PC_I,        // instruction now executing
  input  wire logic        EXEC_VALID_I,     // an instruction executes this cycle
  input  wire logic        EXEC_FETCH_ERR_I, // that instruction carried a fetch error
  input  wire logic        EXEC_CACHED_I,    // it came from the instruction cache
  input  wire ceu_cause_t  EXC_CAUSE_I,
  input  wire logic [31:0] EXC_SYN_BITS_I,
  input  wire logic [31:0] EXC_DATA_ADDR_I,
  input  wire logic        RFCI_I,           // return-from-critical executes
  output logic             TAKE_O,           // redirect this cycle
  output logic      [31:0] TARGET_O,
  output logic             ICACHE_INVAL_O,
  output logic      [31:0] ICACHE_INVAL_ADDR_O,
  output logic      [31:0] MACHINE_STATE_O
);

  typedef struct packed
  {
    logic [31:0] machine_state_register;
    logic [31:0] dfa;
    logic [31:0] csa;
    logic [31:0] css;
    logic [31:0] vpr;
    logic [31:0] rdata;
    logic        take;
    logic [31:0] target;
    logic        inval;
    logic [31:0] inval_addr;
    logic        crit_pulse;
    logic        mchk_pulse;
    logic        ferr_pend;
  } ceu_core_state_t;

  ceu_core_state_t r;
  ceu_core_state_t next_r;
  logic [31:0]     syn;
  logic            fetch_mchk;
  logic            other_exc;
  logic            syn_wr;

  // fetch error counts only when the faulty instruction executes; a bus
  // report waits in ferr_pend for the next instruction to execute
  assign fetch_mchk = EXEC_VALID_I & (EXEC_FETCH_ERR_I | r.ferr_pend); // see RULE_15, RULE_18
  assign other_exc  = (EXC_CAUSE_I == CEU_CAUSE_SYNDROME);
  assign syn_wr     = SPR_WR_I & (SPR_ADDR_I == SPR_SYNDROME);         // see RULE_04

  ceu_syndrome u_syn
  (
    .CORE_CLK_I             (CORE_CLK_I),
    .RESET_I                (RESET_I),
    .machine_check_enable_i (r.machine_state_register[MS_ME]),
    .fetch_mchk_i           (fetch_mchk),
    .other_exc_i            (other_exc),
    .other_bits_i           (EXC_SYN_BITS_I),
    .sw_write_i             (syn_wr),
    .sw_data_i              (SPR_WDATA_I),
    .syndrome_register_o    (syn)
  );

  // --------------------------------------------------------------
  // interrupt decisions and special registers
  // --------------------------------------------------------------
  always_comb
  begin
    logic mchk_go;
    logic crit_go;
    mchk_go = 1'b0;
    crit_go = 1'b0;
    next_r  = r;
    next_r.take       = 1'b0;
    next_r.inval      = 1'b0;
    next_r.crit_pulse = 1'b0;
    next_r.mchk_pulse = 1'b0;
    next_r.rdata      = 32'h0000_0000;
    // software writes
    if (SPR_WR_I)
    begin
      case (SPR_ADDR_I)
        SPR_DATA_FAULT: next_r.dfa = SPR_WDATA_I;                      // see RULE_06
        SPR_CRIT_ADDR:  next_r.csa = SPR_WDATA_I;
        SPR_CRIT_STATE: next_r.css = SPR_WDATA_I;
        SPR_VEC_PREFIX: next_r.vpr = {SPR_WDATA_I[31:16], 16'h0000};
        default:        next_r.vpr = next_r.vpr;
      endcase
    end
    // reads answer one cycle later
    if (SPR_RD_I)
    begin
      case (SPR_ADDR_I)
        SPR_SYNDROME:   next_r.rdata = syn;                            // see RULE_04
        SPR_DATA_FAULT: next_r.rdata = r.dfa;                          // see RULE_06
        SPR_CRIT_ADDR:  next_r.rdata = r.csa;
        SPR_CRIT_STATE: next_r.rdata = r.css;
        SPR_VEC_PREFIX: next_r.rdata = r.vpr;
        default:        next_r.rdata = 32'h0000_0000;
      endcase
    end
    // data operand address of the faulting access
    if (EXC_CAUSE_I == CEU_CAUSE_DATA_ADDR)
    begin
      next_r.dfa = EXC_DATA_ADDR_I;                                    // see RULE_05
    end
    if (RFCI_I)
    begin
      next_r.machine_state_register = r.css;                                              // see RULE_22
    end
    // errors are levels sampled each edge; a disabled data error simply vanishes, a disabled fetch error still sets the flag
    mchk_go = r.machine_state_register[MS_ME] & (fetch_mchk | LINK.data_bus_err);         // see RULE_15, RULE_16, RULE_24
    crit_go = r.machine_state_register[MS_CE] & LINK.crit_req & ~mchk_go;                 // see RULE_10
    if (mchk_go)
    begin
      next_r.css        = r.machine_state_register;
      next_r.csa        = fetch_mchk ? EXEC_PC_I : NEXT_PC_I;
      next_r.machine_state_register        = r.machine_state_register & ~MCHK_CLEAR_MASK;                    // see RULE_17
      next_r.target     = {r.vpr[31:16], VEC_MACH_CHECK};              // see RULE_14, RULE_23
      next_r.take       = 1'b1;
      next_r.mchk_pulse = 1'b1;
    end
    else if (crit_go)
    begin
      next_r.csa        = NEXT_PC_I;                                   // see RULE_12
      next_r.css        = r.machine_state_register;                                       // see RULE_13
      next_r.machine_state_register        = r.machine_state_register & ~CRIT_CLEAR_MASK;                    // see RULE_11, RULE_13
      next_r.target     = {r.vpr[31:16], VEC_CRIT_INPUT};              // see RULE_07, RULE_23
      next_r.take       = 1'b1;
      next_r.crit_pulse = 1'b1;
    end
    // the instruction-side bus error is held until an instruction executes,
    // so a report is never dropped; limitation: it is charged to the next
    // instruction that executes. a new report beside an execution wins
    if (LINK.fetch_bus_err)
    begin
      next_r.ferr_pend = 1'b1;                                         // see RULE_16, RULE_24
    end
    else if (EXEC_VALID_I)
    begin
      next_r.ferr_pend = 1'b0;
    end
    // a cached faulty instruction loses its line, enabled or not
    if (fetch_mchk && EXEC_CACHED_I)
    begin
      next_r.inval      = 1'b1;                                        // see RULE_19
      next_r.inval_addr = EXEC_PC_I;
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  // core state except the syndrome (held in u_syn) in one register; synchronous reset starts every field at zero
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign SPR_RDATA_O         = r.rdata;
  assign TAKE_O              = r.take;
  assign TARGET_O            = r.target;
  assign ICACHE_INVAL_O      = r.inval;
  assign ICACHE_INVAL_ADDR_O = r.inval_addr;
  assign MACHINE_STATE_O     = r.machine_state_register;
  assign LINK.crit_taken     = r.crit_pulse;
  assign LINK.mchk_taken     = r.mchk_pulse;

endmodule

/* File: logic/ceu_ext.sv */
`timescale 1ns/1ns
// interrupt controller and bus error sources facing the core
module ceu_ext
  import ceu_pkg::*;
(
  input  wire logic CORE_CLK_I,
  input  wire logic RESET_I,
  ceu_link_if.ext   LINK,
  input  wire logic CRIT_EVENT_I,     // source raising a critical request
  input  wire logic STATUS_CLEAR_I,   // control-register write clearing status
  input  wire logic FETCH_ERR_I,      // slave saw an error on a fetch
  input  wire logic DATA_ERR_I,       // slave saw an error on a data access
  output logic      CRIT_PENDING_O,
  output logic      CRIT_TAKEN_O,
  output logic      MCHK_TAKEN_O
);

  typedef struct packed
  {
    logic pend;
    logic ferr;
    logic derr;
  } ceu_ext_state_t;

  ceu_ext_state_t r;
  ceu_ext_state_t next_r;

  // --------------------------------------------------------------
  // request held until cleared; set wins over clear
  // --------------------------------------------------------------
  always_comb
  begin
    next_r      = r;
    next_r.pend = (r.pend & ~STATUS_CLEAR_I) | CRIT_EVENT_I;  // see RULE_08, RULE_09
    next_r.ferr = FETCH_ERR_I;                                 // see RULE_15
    next_r.derr = DATA_ERR_I;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign LINK.crit_req      = r.pend;
  assign LINK.fetch_bus_err = r.ferr;
  assign LINK.data_bus_err  = r.derr;
  assign CRIT_PENDING_O     = r.pend;
  assign CRIT_TAKEN_O       = LINK.crit_taken;
  assign MCHK_TAKEN_O       = LINK.mchk_taken;

endmodule

/* File: verification/ceu_props.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// link checks between core and controller
// ----------------------------------------------------------------
module ceu_props
(
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic crit_req,
  input wire logic fetch_bus_err,
  input wire logic data_bus_err,
  input wire logic crit_taken,
  input wire logic mchk_taken
);
  default clocking dcb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RESET_I);

  // a take clears critical enable, so no critical take can follow at once; a machine check also clears machine check enable
  AST_CRIT_QUIET:
    assert property (crit_taken |=> !crit_taken [*4]) else $error("critical take repeated");
  AST_MCHK_QUIET:
    assert property (mchk_taken |=> !mchk_taken [*4]) else $error("machine check repeated");
  AST_MCHK_NO_CRIT:
    assert property (mchk_taken |=> !crit_taken [*4]) else $error("critical take after machine check");
  AST_ONE_KIND:
    assert property (!(crit_taken && mchk_taken)) else $error("both takes at once");
  AST_CRIT_CAUSE:
    assert property (crit_taken |-> $past(crit_req)) else $error("critical take without request");
  AST_CRIT_HELD:
    assert property (crit_taken |-> crit_req) else $error("request dropped before clear");
  AST_REQ_PERSIST:
    assert property ($rose(crit_req) |=> crit_req [*2]) else $error("critical request not held");
  // reset is synchronous: one edge in reset leaves every link line low
  AST_RESET_QUIET:
    assert property (disable iff (1'b0) RESET_I |=> !(crit_req || fetch_bus_err || data_bus_err
                     || crit_taken || mchk_taken)) else $error("link active after reset");

  cover property (crit_taken);
  cover property (mchk_taken);
  cover property (crit_req && !crit_taken [*4]);
endmodule

/* File: verification/critical_exception_unit_tb.sv */
`timescale 1ns/1ns
module critical_exception_unit_tb
  import ceu_pkg::*;
;
  typedef struct packed {logic k; logic [31:0] t; logic [31:0] s; logic [31:0] a;} ceu_exp_t;
  localparam logic [31:0] CE_B = 32'(1) << MS_CE;
  localparam logic [31:0] ME_B = 32'(1) << MS_ME;
  localparam logic [31:0] FLAG = 32'h8000_0000;
  logic             clk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, rfci = 0;
  logic             ev = 0, clr = 0, ferr = 0, derr = 0, xv = 0, xf = 0, xc = 0;
  logic             take, inv, pend, ctk, mtk;
  logic [9:0]       addr = '0;
  logic [31:0]      wdata = '0, npc = '0, epc = '0, sbits = '0, daddr = '0;
  logic [31:0]      rdata, tgt, inva, mst, d, b, s;
  logic [15:0]      pfx;
  ceu_cause_t       cause = CEU_CAUSE_NONE;
  ceu_exp_t         x;
  ceu_exp_t         tq[$];
  logic [31:0]      rq[$];
  logic [9:0]       al[6] = '{SPR_SYNDROME, SPR_DATA_FAULT, SPR_VEC_PREFIX, SPR_CRIT_ADDR, SPR_CRIT_STATE, 10'h3FF};
  int               n_errors = 0, n_checks = 0, cyc = 0;

  ceu_link_if ceu_link_if_i();
  ceu_core ceu_core_i(.CORE_CLK_I(clk), .RESET_I(rst), .LINK(ceu_link_if_i), .SPR_ADDR_I(addr),
    .SPR_WDATA_I(wdata), .SPR_WR_I(wr), .SPR_RD_I(rd), .SPR_RDATA_O(rdata), .NEXT_PC_I(npc),
    .EXEC_PC_I(epc), .EXEC_VALID_I(xv), .EXEC_FETCH_ERR_I(xf), .EXEC_CACHED_I(xc), .EXC_CAUSE_I(cause),
    .EXC_SYN_BITS_I(sbits), .EXC_DATA_ADDR_I(daddr), .RFCI_I(rfci), .TAKE_O(take), .TARGET_O(tgt),
    .ICACHE_INVAL_O(inv), .ICACHE_INVAL_ADDR_O(inva), .MACHINE_STATE_O(mst));
  ceu_ext ceu_ext_i(.CORE_CLK_I(clk), .RESET_I(rst), .LINK(ceu_link_if_i), .CRIT_EVENT_I(ev),
    .STATUS_CLEAR_I(clr), .FETCH_ERR_I(ferr), .DATA_ERR_I(derr), .CRIT_PENDING_O(pend), .CRIT_TAKEN_O(ctk),
    .MCHK_TAKEN_O(mtk));
  ceu_props ceu_props_i(.CORE_CLK_I(clk), .RESET_I(rst), .crit_req(ceu_link_if_i.crit_req),
    .fetch_bus_err(ceu_link_if_i.fetch_bus_err), .data_bus_err(ceu_link_if_i.data_bus_err),
    .crit_taken(ceu_link_if_i.crit_taken), .mchk_taken(ceu_link_if_i.mchk_taken));

  always #4 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one register cycle; a read queues its expected word in rq
  task spr(input logic w, input logic [9:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    if (!w)
      rq.push_back(v);
    @(posedge clk);
    wr <= 0;
    rd <= 0;
  endtask

  // one-cycle pulse on {rfci, event, clear, fetch error, data error}
  task pulse(input logic [4:0] m);
    @(posedge clk);
    {rfci, ev, clr, ferr, derr} <= m;
    @(posedge clk);
    {rfci, ev, clr, ferr, derr} <= '0;
  endtask

  task exec(input logic v, input logic f, input logic c, input ceu_cause_t k, input logic [31:0] bb,
            input logic [31:0] da);
    @(posedge clk);
    {xv, xf, xc} <= {v, f, c};
    cause <= k;
    sbits <= bb;
    daddr <= da;
    @(posedge clk);
    {xv, xf, xc} <= '0;
    cause <= CEU_CAUSE_NONE;
  endtask

  // software sets state only through the critical return, so load save state first
  task set_state(input logic [31:0] v);
    spr(1, SPR_CRIT_STATE, v);
    pulse(5'b10000);
  endtask

  task want(input logic k, input logic [15:0] off, input logic [31:0] st, input logic [31:0] ia);
    tq.push_back('{k, {pfx, off}, st, ia});
  endtask

  task done(input string nm);
    repeat (10) @(posedge clk);
    chk("pending takes", 32'h0, 32'(tq.size()));
    tq.delete();
    $display("test %s done", nm);
  endtask

  // ----------------------------------------------------------------
  // result watcher: oldest note against each result that shows
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst && rd_d)
      chk("read data", rq.pop_front(), rdata);
    if (!rst && take && tq.size() == 0)
      chk("unexpected take", 32'h0, tgt);
    else if (!rst && take)
    begin
      x = tq.pop_front();
      chk("target", x.t, tgt);
      chk("state", x.s, mst);
      chk("critical pulse", {31'h0, x.k}, {31'h0, ceu_link_if_i.crit_taken});
      chk("check pulse", {31'h0, !x.k}, {31'h0, ceu_link_if_i.mchk_taken});
      chk("controller pulses", {30'h0, x.k, !x.k}, {30'h0, ctk, mtk});
      chk("invalidate", {31'h0, x.a != 0}, {31'h0, inv});
      if (x.a != 0)
        chk("invalidate address", x.a, inva);
    end
    rd_d <= rd;
    cyc++;
    // the whole run needs well under a thousand cycles
    if (cyc > 5000)
    begin
      n_errors++;
      finish_test;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    d = $urandom(32'h6b87a32f);
    npc = $urandom;
    epc = $urandom | 32'h0000_0004;
    pfx = '0;
    repeat (12) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 6; i++)
      spr(0, al[i], 32'h0);
    done("reset");
    d = $urandom;
    spr(1, SPR_DATA_FAULT, d);
    spr(0, SPR_DATA_FAULT, d);
    d = $urandom;
    spr(1, SPR_SYNDROME, d);
    spr(0, SPR_SYNDROME, d);
    b = $urandom;
    pfx = b[31:16];
    spr(1, SPR_VEC_PREFIX, b);
    spr(0, SPR_VEC_PREFIX, {pfx, 16'h0000});
    spr(1, 10'h3FF, b);
    spr(0, 10'h3FF, 32'h0);
    done("registers");
    // critical request while disabled must wait for the enable
    pulse(5'b01000);
    repeat (8) @(posedge clk);
    chk("pending", 32'h1, {31'h0, pend});
    s = $urandom | CE_B | ME_B;
    want(1, VEC_CRIT_INPUT, s & ~CRIT_CLEAR_MASK, 32'h0);
    set_state(s);
    spr(0, SPR_CRIT_ADDR, npc);
    spr(0, SPR_CRIT_STATE, s);
    spr(0, SPR_SYNDROME, d);
    pulse(5'b00100);
    @(posedge clk);
    chk("pending", 32'h0, {31'h0, pend});
    done("critical input");
    s = $urandom | CE_B | ME_B;
    set_state(s);
    want(0, VEC_MACH_CHECK, s & ~MCHK_CLEAR_MASK, 32'h0);
    pulse(5'b01001);
    spr(0, SPR_CRIT_ADDR, npc);
    repeat (6) @(posedge clk);
    pulse(5'b00100);
    pulse(5'b00001);
    set_state(ME_B);
    done("data check");
    exec(0, 1, 1, CEU_CAUSE_NONE, 32'h0, 32'h0);
    spr(1, SPR_SYNDROME, $urandom);
    want(0, VEC_MACH_CHECK, 32'h0, epc);
    exec(1, 1, 1, CEU_CAUSE_NONE, 32'h0, 32'h0);
    spr(0, SPR_SYNDROME, FLAG);
    spr(0, SPR_CRIT_ADDR, epc);
    done("fetch check");
    b = $urandom & 32'h7FFF_FFFF;
    spr(1, SPR_SYNDROME, 32'h0);
    exec(1, 1, 0, CEU_CAUSE_NONE, 32'h0, 32'h0);
    spr(0, SPR_SYNDROME, FLAG);
    spr(1, SPR_SYNDROME, 32'h0);
    pulse(5'b00010);
    exec(1, 0, 0, CEU_CAUSE_NONE, 32'h0, 32'h0);
    spr(0, SPR_SYNDROME, FLAG);
    exec(0, 0, 0, CEU_CAUSE_SYNDROME, b, 32'h0);
    spr(0, SPR_SYNDROME, b | FLAG);
    spr(1, SPR_SYNDROME, 32'h0);
    exec(1, 1, 0, CEU_CAUSE_SYNDROME, b, 32'h0);
    spr(0, SPR_SYNDROME, b | FLAG);
    spr(1, SPR_SYNDROME, 32'h0);
    exec(0, 0, 0, CEU_CAUSE_SYNDROME, b, 32'h0);
    spr(0, SPR_SYNDROME, b);
    set_state(ME_B);
    spr(1, SPR_SYNDROME, FLAG);
    exec(0, 0, 0, CEU_CAUSE_SYNDROME, b, 32'h0);
    spr(0, SPR_SYNDROME, b);
    done("syndrome");
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom;
      exec(0, 0, 0, CEU_CAUSE_DATA_ADDR, 32'h0, d);
      spr(0, SPR_DATA_FAULT, d);
    end
    done("fault address");
    finish_test;
  end
endmodule
